/* File: rtl/cmp_bus_if.sv */
// Purpose: Carries one comparator's stored values to its match unit.
// Assumes: Single clock domain.
// Notes: Data fields are unused on address-only comparators.
`timescale 1ns/1ps
interface cmp_bus_if;
  logic [22:0] addr_val;
  logic [15:0] data_val;
  logic [15:0] data_mask;
  logic data_sense;
  logic has_data;
  modport source (output addr_val, data_val, data_mask, data_sense, has_data);
  modport sink (input addr_val, data_val, data_mask, data_sense, has_data);
endinterface : cmp_bus_if

/* File: rtl/cmp_match_pkg.sv */
// Purpose: Constants shared by the debug comparator match register block.
// Assumes: Registers reached over a plain strobe port with byte data.
// Notes: Offsets are byte addresses in the debug register map.
package cmp_match_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_BUS_W = 23;
  localparam int DATA_BUS_W = 16;
  localparam int REG_ADDR_W = 8;
  localparam int NUM_CMP = 4;

  // ----------------------------------------
  // Register offsets inside the shared window
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h28;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h29;
  localparam logic [7:0] OFS_ADDR_MID = 8'h2a;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h2b;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h2c;
  localparam logic [7:0] OFS_DATA_LOW = 8'h2d;
  localparam logic [7:0] OFS_DATA_HIGH_MASK = 8'h2e;
  localparam logic [7:0] OFS_DATA_LOW_MASK = 8'h2f;
  // Module-level control outside the window
  localparam logic [7:0] OFS_MODULE_CTRL = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_SENSE_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int MOD_ARM_BIT = 7;
  localparam int MOD_SEL_LSB = 0;
  localparam logic [7:0] ADDR_HIGH_USED = 8'h7f;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;

endpackage : cmp_match_pkg

/* File: rtl/cmp_match_unit.sv */
// Purpose: Combinational address and data match for one comparator.
// Assumes: Bus values are already synchronous to the clock.
// Notes: Result is registered by the top module.
`timescale 1ns/1ps
module cmp_match_unit (
  // Stored values
  cmp_bus_if.sink cfg,
  // Watched buses
  input wire logic [22:0] bus_addr,
  input wire logic [15:0] bus_data,
  // Result
  output logic hit
);

  logic addr_eq;
  logic data_ok;
  logic [15:0] diff;

  // Address must match on all bits
  assign addr_eq = (bus_addr == cfg.addr_val);
  // Masked data difference; clear mask bits never count
  assign diff = (bus_data ^ cfg.data_val) & cfg.data_mask;
  // Sense clear wants equality, set wants any masked difference
  assign data_ok = !cfg.has_data ? 1'b1 : (cfg.data_sense ? (diff != 16'h0000) : (diff == 16'h0000));
  assign hit = addr_eq && data_ok;

endmodule : cmp_match_unit

/* File: rtl/debug_comparator_match_regs.sv */
// Purpose: Comparator address, data and mask registers with match outputs.
// Assumes: Processor bus inputs are on this clock; strobes from local logic.
// Notes: Four comparators share one window chosen by comparator_window_select.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module debug_comparator_match_regs
  import cmp_match_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Watched processor buses
  input wire logic [22:0] cpu_addr,
  input wire logic [15:0] cpu_data,
  input wire logic cpu_valid,
  // Results
  output logic [3:0] match,
  output logic armed
);

  // ----------------------------------------
  // Stored state
  // ----------------------------------------
  logic [1:0] comparator_window_select_q;
  logic arm_q;
  logic [7:0] ctrl_q [NUM_CMP];
  logic [6:0] addr_high_q [NUM_CMP];
  logic [7:0] addr_mid_q [NUM_CMP];
  logic [7:0] addr_low_q [NUM_CMP];
  logic [7:0] data_high_q [NUM_CMP];
  logic [7:0] data_low_q [NUM_CMP];
  logic [7:0] data_high_mask_q [NUM_CMP];
  logic [7:0] data_low_mask_q [NUM_CMP];
  logic [7:0] reg_rdata_q;
  logic [3:0] match_q;
  logic [3:0] hit;
  logic win_sel;
  logic win_wr;

  // Window decode
  assign win_sel = (reg_addr >= OFS_CONTROL) && (reg_addr <= OFS_DATA_LOW_MASK);
  assign win_wr = reg_wr && win_sel && !arm_q;

  // ----------------------------------------
  // Module control: arm and window select
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      arm_q <= 1'b0;
      comparator_window_select_q <= 2'b00;
    end else if (reg_wr && reg_addr == OFS_MODULE_CTRL) begin
      arm_q <= reg_wdata[MOD_ARM_BIT];
      // Select may only move while disarmed, so the window stays stable
      if (!arm_q) begin
        comparator_window_select_q <= reg_wdata[MOD_SEL_LSB +: 2];
      end
    end
  end

  // ----------------------------------------
  // Per-comparator registers and match units
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      localparam bit HAS_DATA = (g == 0) || (g == 2);
      logic this_wr;
      cmp_bus_if cbus ();
      assign this_wr = win_wr && (comparator_window_select_q == 2'(g));

      // Control and address registers, all comparators
      always_ff @(posedge clock) begin
        if (srst) begin
          ctrl_q[g] <= RST_REG;
          addr_high_q[g] <= 7'h00;
          addr_mid_q[g] <= RST_REG;
          addr_low_q[g] <= RST_REG;
        end else if (this_wr) begin
          unique case (reg_addr)
            OFS_CONTROL: ctrl_q[g] <= reg_wdata;
            OFS_ADDR_HIGH: addr_high_q[g] <= reg_wdata[6:0];
            OFS_ADDR_MID: addr_mid_q[g] <= reg_wdata;
            OFS_ADDR_LOW: addr_low_q[g] <= reg_wdata;
            default: ;
          endcase
        end
      end

      // Data and mask registers only exist where data compare does
      if (HAS_DATA) begin : g_data
        always_ff @(posedge clock) begin
          if (srst) begin
            data_high_q[g] <= RST_REG;
            data_low_q[g] <= RST_REG;
            data_high_mask_q[g] <= RST_REG;
            data_low_mask_q[g] <= RST_REG;
          end else if (this_wr) begin
            unique case (reg_addr)
              OFS_DATA_HIGH: data_high_q[g] <= reg_wdata;
              OFS_DATA_LOW: data_low_q[g] <= reg_wdata;
              OFS_DATA_HIGH_MASK: data_high_mask_q[g] <= reg_wdata;
              OFS_DATA_LOW_MASK: data_low_mask_q[g] <= reg_wdata;
              default: ;
            endcase
          end
        end
      end else begin : g_nodata
        // Held at zero by a clocked process so every element has one procedural driver kind
        always_ff @(posedge clock) begin
          data_high_q[g] <= RST_REG;
          data_low_q[g] <= RST_REG;
          data_high_mask_q[g] <= RST_REG;
          data_low_mask_q[g] <= RST_REG;
        end
      end

      // Values to the match unit
      assign cbus.addr_val = {addr_high_q[g], addr_mid_q[g], addr_low_q[g]};
      assign cbus.data_val = {data_high_q[g], data_low_q[g]};
      assign cbus.data_mask = {data_high_mask_q[g], data_low_mask_q[g]};
      assign cbus.data_sense = HAS_DATA ? ctrl_q[g][CTRL_SENSE_BIT] : 1'b0;
      assign cbus.has_data = HAS_DATA;

      cmp_match_unit u_unit (
        .cfg(cbus.sink),
        .bus_addr(cpu_addr),
        .bus_data(cpu_data),
        .hit(hit[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Match outputs
  // ----------------------------------------
  // Registered so the output is glitch free; one cycle behind the bus
  always_ff @(posedge clock) begin
    if (srst) begin
      match_q <= 4'h0;
    end else begin
      match_q <= cpu_valid ? hit : 4'h0;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Reads ignore arming entirely; missing data registers read zero
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata_q <= RST_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_MODULE_CTRL: reg_rdata_q <= {arm_q, 5'h00, comparator_window_select_q};
        OFS_CONTROL: reg_rdata_q <= ctrl_q[comparator_window_select_q];
        OFS_ADDR_HIGH: reg_rdata_q <= {1'b0, addr_high_q[comparator_window_select_q]};
        OFS_ADDR_MID: reg_rdata_q <= addr_mid_q[comparator_window_select_q];
        OFS_ADDR_LOW: reg_rdata_q <= addr_low_q[comparator_window_select_q];
        OFS_DATA_HIGH: reg_rdata_q <= data_high_q[comparator_window_select_q];
        OFS_DATA_LOW: reg_rdata_q <= data_low_q[comparator_window_select_q];
        OFS_DATA_HIGH_MASK: reg_rdata_q <= data_high_mask_q[comparator_window_select_q];
        OFS_DATA_LOW_MASK: reg_rdata_q <= data_low_mask_q[comparator_window_select_q];
        default: reg_rdata_q <= RST_REG;
      endcase
    end else begin
      reg_rdata_q <= RST_REG;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign match = match_q;
  assign armed = arm_q;

endmodule : debug_comparator_match_regs

/* File: testbench/cmp_match_monitor.sv */
// Purpose: Port checks for the comparator match registers.
// Assumes: One clock, synchronous reset.
// Notes: Keeps its own copy of the window select.
`timescale 1ns/1ps
module cmp_match_monitor
  import cmp_match_pkg::*;
(
  // Clock and register port
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Buses and results
  input wire logic [22:0] cpu_addr,
  input wire logic [15:0] cpu_data,
  input wire logic cpu_valid,
  input wire logic [3:0] match,
  input wire logic armed
);
  logic [1:0] sel_q;
  wire ctl_wr = reg_wr && reg_addr == OFS_MODULE_CTRL;
  // Select moves only while disarmed
  always_ff @(posedge clock) begin
    if (srst) sel_q <= 2'h0;
    else if (ctl_wr && !armed) sel_q <= reg_wdata[1:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  AST_RD_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("data without read");
  AST_NO_HIT_IDLE: assert property (!cpu_valid |=> match == 4'h0) else $error("hit while idle");
  AST_ARM_SET: assert property (ctl_wr |=> armed == $past(reg_wdata[7])) else $error("arm lost");
  AST_ARM_HOLD: assert property (!ctl_wr |=> $stable(armed)) else $error("arm moved");
  AST_AH_BIT7: assert property (reg_rd && reg_addr == OFS_ADDR_HIGH |=> !reg_rdata[7]) else $error("bit7 set");
  AST_ADDR_ONLY: assert property (reg_rd && sel_q[0] && reg_addr >= OFS_DATA_HIGH && reg_addr <= 8'h2f
    |=> reg_rdata == 8'h00) else $error("data reg on address-only");
  AST_READBACK: assert property (reg_wr && !armed && (reg_addr == OFS_ADDR_MID || reg_addr == OFS_ADDR_LOW) ##1
    (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > OFS_DATA_LOW_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read");
endmodule : cmp_match_monitor
bind debug_comparator_match_regs cmp_match_monitor cmp_match_monitor_i (.*);

/* File: testbench/cpu_bus_model.sv */
// Purpose: Processor bus model feeding the comparators.
// Assumes: The bench requests one access per cycle.
// Notes: Idle buses show inverted last values.
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock and requests
  input wire logic clock,
  input wire logic go,
  input wire logic [22:0] req_addr,
  input wire logic [15:0] req_data,
  // Watched buses
  output logic [22:0] cpu_addr,
  output logic [15:0] cpu_data,
  output logic cpu_valid
);
  // Toggling when idle, so a stale value never looks valid
  always_ff @(posedge clock) begin
    cpu_valid <= go;
    cpu_addr <= go ? req_addr : ~cpu_addr;
    cpu_data <= go ? req_data : ~cpu_data;
  end
endmodule : cpu_bus_model

/* File: testbench/debug_comparator_match_regs_tb_top.sv */
// Purpose: Self-checking bench for the comparator match registers.
// Assumes: Model follows the ports at every edge.
// Notes: Random values from an xorshift seeded with 22.
`timescale 1ns/1ps
module debug_comparator_match_regs_tb_top
  import cmp_match_pkg::*;
;
  logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, exp_rd;
  logic [22:0] req_addr = 23'h00_0000, cpu_addr;
  logic [15:0] req_data = 16'h0000, cpu_data;
  logic cpu_valid, armed, arm_m;
  logic [3:0] match, exp_m;
  logic [1:0] sel_m;
  logic [7:0] m [4][8]; // Model registers by window offset
  logic [31:0] rs = 32'h0000_0016;
  int errors = 0, num_checks = 0;
  // Clock
  initial forever #20 clock = ~clock;
  debug_comparator_match_regs debug_comparator_match_regs_i (.*);
  cpu_bus_model cpu_bus_model_i (.*);
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask : acc
  task automatic bus(input logic g, input logic [22:0] a, input logic [15:0] d);
    go <= g;
    req_addr <= a;
    req_data <= d;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Reference model, stepped at the edge the design samples
  always @(posedge clock) begin : model
    logic [15:0] x;
    int k;
    if (srst) begin
      m = '{default: 8'h00};
      {arm_m, sel_m, exp_rd, exp_m} = '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        x = ({m[i][4], m[i][5]} ^ cpu_data) & {m[i][6], m[i][7]};
        exp_m[i] = cpu_valid && cpu_addr == {m[i][1][6:0], m[i][2], m[i][3]}
          && (i[0] || (m[i][0][6] ? |x : ~|x));
      end
      k = reg_addr - OFS_CONTROL;
      exp_rd = (reg_rd && k >= 0 && k < 8) ? m[sel_m][k] : 8'h00;
      if (reg_wr && reg_addr == OFS_MODULE_CTRL) begin
        if (!arm_m) sel_m = reg_wdata[1:0];
        arm_m = reg_wdata[MOD_ARM_BIT];
      end
      if (reg_wr && !arm_m && k >= 0 && k < 8 && !(sel_m[0] && k > 3))
        m[sel_m][k] = (k == 1) ? reg_wdata & ADDR_HIGH_USED : reg_wdata;
    end
    #1;
    chk(reg_rdata, exp_rd);
    chk({4'h0, match}, {4'h0, exp_m});
    chk({7'h00, armed}, {7'h00, arm_m});
  end
  // Scenarios: every select, readback, armed writes, unmapped reads, reset
  initial begin : stim
    logic [31:0] v;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    for (int r = 0; r < 24; r++) begin
      acc(1'b1, OFS_MODULE_CTRL, {6'h00, r[1:0]});
      for (int k = 0; k < 8; k++) begin
        v = rnd();
        acc(1'b0, OFS_CONTROL + k[7:0], 8'h00);
        acc(1'b1, OFS_CONTROL + k[7:0], v[7:0]);
        acc(1'b0, OFS_CONTROL + k[7:0], 8'h00);
      end
      acc(1'b0, 8'h30 + r[7:0], 8'h00);
      if (r % 3 == 2) begin
        acc(1'b1, OFS_MODULE_CTRL, {6'h20, ~r[1:0]});
        for (int k = 0; k < 8; k++) begin
          v = rnd();
          acc(1'b1, OFS_CONTROL + k[7:0], v[7:0]);
          acc(1'b0, OFS_CONTROL + k[7:0], 8'h00);
        end
      end
      repeat (8) begin
        v = rnd();
        bus(v[0] | v[3], {m[r%4][1][6:0], m[r%4][2], m[r%4][3]} ^ (v[1] ? 23'h00_0000 : 23'h00_0001 << v[8:4]),
          {m[r%4][4], m[r%4][5]} ^ (v[2] ? 16'h0000 : v[31:16]));
      end
      acc(1'b1, OFS_MODULE_CTRL, 8'h00);
    end
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    acc(1'b0, OFS_ADDR_LOW, 8'h00);
    bus(1'b0, 23'h00_0000, 16'h0000);
    @(posedge clock);
    complete_run();
  end
  // Watchdog, several times the expected run length
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : debug_comparator_match_regs_tb_top
